// ---- rtl/sss_pkg.sv ----
package sss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Settling time given to each entry or exit step of a sequence.
  localparam int STEP_TIME_NS = 100;
  // Time the processor and device resets are held after the last exit step has settled.
  localparam int RESET_TIME_NS = 1000;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] STEP_CYCLES =
    CNT_W'((STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_CYCLES =
    CNT_W'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Sleep type codes
  // ----------------------------------------------------------------
  localparam int TYPE_W = 3;
  localparam logic [TYPE_W-1:0] TYPE_S1_DEF = 3'h1;
  localparam logic [TYPE_W-1:0] TYPE_S2_DEF = 3'h2;
  localparam logic [TYPE_W-1:0] TYPE_S3_DEF = 3'h3;
  localparam logic [TYPE_W-1:0] TYPE_S4_DEF = 3'h4;

  // ----------------------------------------------------------------
  // Sequencer targets and control bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] TGT_NONE = 3'h0;
  localparam logic [2:0] TGT_S1L = 3'h1;
  localparam logic [2:0] TGT_S1D = 3'h2;
  localparam logic [2:0] TGT_S2 = 3'h3;
  localparam logic [2:0] TGT_S3 = 3'h4;
  localparam logic [2:0] TGT_S4 = 3'h5;

  localparam int NUM_CB = 8;
  localparam int CB_STOP = 0;
  localparam int CB_HALT = 1;
  localparam int CB_SREF = 2;
  localparam int CB_STBY = 3;
  localparam int CB_CPUOFF = 4;
  localparam int CB_ISO = 5;
  localparam int CB_SYSOFF = 6;
  localparam int CB_MEMOFF = 7;
  localparam logic [NUM_CB-1:0] CTL_RESET = 8'h00;

  localparam logic [1:0] IDX_FIRST = 2'h0;
  localparam logic [1:0] IDX_ONE = 2'h1;

endpackage

// ---- rtl/sss_step_timer.sv ----
`timescale 1ns/10ps
module sss_step_timer #(
  parameter int CNT_W = 16
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_load, // Start a new interval.
  input wire logic [CNT_W-1:0] i_count, // Interval length in cycles.
  output logic o_done // One-cycle pulse at interval end.
);

  logic [CNT_W-1:0] count_ff;
  logic busy_ff;
  logic done_ff;

  // A load while busy restarts the interval, so the caller never sees a
  // stale completion from the step that came before.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (i_load)
    begin
      count_ff <= i_count;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (busy_ff && (count_ff <= CNT_W'(1)))
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b1;
    end
    else
    begin
      count_ff <= busy_ff ? count_ff - CNT_W'(1) : count_ff;
      done_ff <= 1'b0;
    end
  end

  assign o_done = done_ff;

endmodule

// ---- rtl/sss_sleep_sequencer.sv ----
// Summary of operation
// [R1] S1 type plus enable set asserts the processor clock-stop request.
// [R2] Light S1 keeps system and processor bus clocks running.
// [R3] Enabled wake in light S1 drops the clock-stop request.
// [R4] Deep S1 requests stop grant first, then halts processor clock.
// [R5] Deep S1 then puts memory into self-refresh.
// [R6] Deep S1 finally asserts system clock standby, leaving only RTC running.
// [R7] Wake from deep S1 undoes the steps in reverse order.
// [R8] S2 stops system clocks, enters self-refresh, powers off processor and cache.
// [R9] Wake from S2 resets the processor so it restarts at boot vector.
// [R10] During S2 core logic and memory stay powered.
// [R11] S3 entry first places memory into self-refresh.
// [R12] S3 entry isolates memory-keeping devices before power removal.
// [R13] S3 then removes system power, keeping memory support powered.
// [R14] In S3 only the real-time clock runs.
// [R15] Wake from S3 restores power and resets devices and processor.
// [R16] S4 powers off all devices.
// [R17] Software flushes caches before enabling S2 or S3.
// [R18] Software saves all context before requesting OS-initiated S4.
// [R19] Firmware-initiated S4 goes through the firmware command port instead.
// [R20] Firmware restores processor, cache and memory setup after S2/S3 wake.
// [R21] Sleep type is a 3-bit code with platform-chosen values.
// [R22] Software sets enable in the same write that loads sleep type.
// [R23] Wake status bit is set when wakeup occurs while sleeping.
// [R24] Only a write with enable set starts; unknown types are ignored.
`timescale 1ns/10ps
module sss_sleep_sequencer #(
  parameter int NUM_WAKE = 4,
  parameter logic [2:0] TYPE_S1 = sss_pkg::TYPE_S1_DEF,
  parameter logic [2:0] TYPE_S2 = sss_pkg::TYPE_S2_DEF,
  parameter logic [2:0] TYPE_S3 = sss_pkg::TYPE_S3_DEF,
  parameter logic [2:0] TYPE_S4 = sss_pkg::TYPE_S4_DEF
) (
  input wire logic i_clk_sys, // System clock, 100 MHz.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic i_ctl_wr, // Power control register write strobe.
  input wire logic [sss_pkg::TYPE_W-1:0] i_sleep_type_field, // Sleep type.
  input wire logic i_sleep_enable_bit, // Sleep enable in the same write.
  input wire logic i_s1_deep_mode, // Use the deeper S1 form.
  input wire logic [NUM_WAKE-1:0] i_wake_events, // Wake event levels.
  input wire logic [NUM_WAKE-1:0] i_wake_enables, // Wake event enables.
  input wire logic i_wake_status_clr, // Clear wake status.
  output logic o_processor_clock_stop_request, // Stop grant request.
  output logic o_cpu_clk_halt, // Stop processor input clock.
  output logic o_mem_self_refresh, // Memory self-refresh.
  output logic o_sys_clk_standby, // Standby to system clock synthesiser.
  output logic o_cpu_power_off, // Processor and cache power off.
  output logic o_mem_isolate, // Memory-keeping devices isolate.
  output logic o_sys_power_off, // System power removed.
  output logic o_mem_power_off, // Memory support power removed.
  output logic o_cpu_reset, // Processor reset.
  output logic o_device_reset, // Device reset.
  output logic o_wake_status_bit, // Sticky wake status.
  output logic [sss_pkg::TYPE_W-1:0] o_sleep_type, // Last accepted type.
  output logic [4:0] o_seq_state // One-hot sequencer state.
);

  // ----------------------------------------------------------------
  // Step tables
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_WORK = 5'h01,
    ST_ENTER = 5'h02,
    ST_SLEEP = 5'h04,
    ST_EXIT = 5'h08,
    ST_RESET = 5'h10
  } sss_state_e;

  function automatic logic [sss_pkg::NUM_CB-1:0] step_mask(input logic [2:0] tgt, input logic [1:0] idx);
    logic [sss_pkg::NUM_CB-1:0] m;
    m = sss_pkg::CTL_RESET;
    case (tgt)
      sss_pkg::TGT_S1L: m[sss_pkg::CB_STOP] = 1'b1; // R1 R2
      sss_pkg::TGT_S1D: // R4 R5 R6
        case (idx)
          2'h0: m[sss_pkg::CB_STOP] = 1'b1;
          2'h1: m[sss_pkg::CB_HALT] = 1'b1;
          2'h2: m[sss_pkg::CB_SREF] = 1'b1;
          default: m[sss_pkg::CB_STBY] = 1'b1;
        endcase
      sss_pkg::TGT_S2: // R8 R10
        case (idx)
          2'h0: m[sss_pkg::CB_STBY] = 1'b1;
          2'h1: m[sss_pkg::CB_SREF] = 1'b1;
          default: m[sss_pkg::CB_CPUOFF] = 1'b1;
        endcase
      sss_pkg::TGT_S3: // R11 R12 R13 R14
        case (idx)
          2'h0: m[sss_pkg::CB_SREF] = 1'b1;
          2'h1: m[sss_pkg::CB_ISO] = 1'b1;
          2'h2: m[sss_pkg::CB_STBY] = 1'b1;
          default: m[sss_pkg::CB_SYSOFF] = 1'b1;
        endcase
      sss_pkg::TGT_S4: // R16
        case (idx)
          2'h0: m[sss_pkg::CB_STBY] = 1'b1;
          2'h1: m[sss_pkg::CB_SYSOFF] = 1'b1;
          default: m[sss_pkg::CB_MEMOFF] = 1'b1;
        endcase
      default: m = sss_pkg::CTL_RESET;
    endcase
    return m;
  endfunction

  function automatic logic [1:0] last_idx(input logic [2:0] tgt);
    logic [1:0] l;
    l = 2'h0;
    case (tgt)
      sss_pkg::TGT_S1D: l = 2'h3;
      sss_pkg::TGT_S2: l = 2'h2;
      sss_pkg::TGT_S3: l = 2'h3;
      sss_pkg::TGT_S4: l = 2'h2;
      default: l = 2'h0;
    endcase
    return l;
  endfunction

  // ----------------------------------------------------------------
  // Decode and events
  // ----------------------------------------------------------------
  sss_state_e state_ff;
  logic [2:0] tgt_ff;
  logic [1:0] idx_ff;
  logic [sss_pkg::NUM_CB-1:0] ctl_ff;
  logic pend_ff;
  logic wake_sts_ff;
  logic cpu_rst_ff;
  logic dev_rst_ff;
  logic [sss_pkg::TYPE_W-1:0] type_ff;
  logic [2:0] req_tgt;
  logic go;
  logic hit;
  logic done;
  logic last;
  logic first;
  logic wake_go;
  logic need_rst;
  logic tmr_load;
  logic [sss_pkg::CNT_W-1:0] tmr_count;

  always_comb
  begin
    req_tgt = sss_pkg::TGT_NONE;
    if (i_sleep_type_field == TYPE_S1)
      req_tgt = i_s1_deep_mode ? sss_pkg::TGT_S1D : sss_pkg::TGT_S1L;
    else if (i_sleep_type_field == TYPE_S2)
      req_tgt = sss_pkg::TGT_S2;
    else if (i_sleep_type_field == TYPE_S3)
      req_tgt = sss_pkg::TGT_S3;
    else if (i_sleep_type_field == TYPE_S4)
      req_tgt = sss_pkg::TGT_S4;
  end

  assign go = (state_ff == ST_WORK) && i_ctl_wr && i_sleep_enable_bit && (req_tgt != sss_pkg::TGT_NONE); // R24
  assign hit = |(i_wake_events & i_wake_enables);
  assign last = (idx_ff == last_idx(tgt_ff));
  assign first = (idx_ff == sss_pkg::IDX_FIRST);
  assign wake_go = (state_ff == ST_SLEEP) && pend_ff;
  assign need_rst = (tgt_ff == sss_pkg::TGT_S2) || (tgt_ff == sss_pkg::TGT_S3) || (tgt_ff == sss_pkg::TGT_S4);
  assign tmr_load = go || wake_go || ((state_ff == ST_ENTER) && done && !last) ||
                    ((state_ff == ST_EXIT) && done && (!first || need_rst));
  assign tmr_count = ((state_ff == ST_EXIT) && first) ? sss_pkg::RESET_CYCLES : sss_pkg::STEP_CYCLES;

  sss_step_timer #(
    .CNT_W(sss_pkg::CNT_W)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(done)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_WORK;
      tgt_ff <= sss_pkg::TGT_NONE;
      idx_ff <= sss_pkg::IDX_FIRST;
    end
    else
    begin
      unique case (state_ff)
        ST_WORK:
          if (go)
          begin
            state_ff <= ST_ENTER;
            tgt_ff <= req_tgt;
            idx_ff <= sss_pkg::IDX_FIRST;
          end
        ST_ENTER:
          if (done)
          begin
            if (last)
              state_ff <= ST_SLEEP;
            else
              idx_ff <= 2'(idx_ff + sss_pkg::IDX_ONE);
          end
        ST_SLEEP:
          if (pend_ff) // R3 R7
          begin
            state_ff <= ST_EXIT;
            idx_ff <= last_idx(tgt_ff);
          end
        ST_EXIT:
          if (done)
          begin
            if (first)
              state_ff <= need_rst ? ST_RESET : ST_WORK;
            else
              idx_ff <= 2'(idx_ff - sss_pkg::IDX_ONE);
          end
        ST_RESET:
          if (done)
            state_ff <= ST_WORK;
      endcase
    end
  end

  // Steps are applied the cycle the timer is loaded, so each control bit
  // has a full settling interval before the next one changes.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctl_ff <= sss_pkg::CTL_RESET;
    else if (go)
      ctl_ff <= ctl_ff | step_mask(req_tgt, sss_pkg::IDX_FIRST); // R1 R4 R11
    else if ((state_ff == ST_ENTER) && done && !last)
      ctl_ff <= ctl_ff | step_mask(tgt_ff, 2'(idx_ff + sss_pkg::IDX_ONE)); // R5 R6 R8 R12 R13 R16
    else if (wake_go)
      ctl_ff <= ctl_ff & ~step_mask(tgt_ff, idx_ff); // R3 R7
    else if ((state_ff == ST_EXIT) && done && !first)
      ctl_ff <= ctl_ff & ~step_mask(tgt_ff, 2'(idx_ff - sss_pkg::IDX_ONE)); // R7 R15
  end

  // Resets are raised in the same cycle the first exit step is undone, so the processor
  // never runs on a half-restored platform.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cpu_rst_ff <= 1'b0;
      dev_rst_ff <= 1'b0;
    end
    else if (wake_go)
    begin
      cpu_rst_ff <= need_rst; // R9 R15
      dev_rst_ff <= (tgt_ff == sss_pkg::TGT_S3) || (tgt_ff == sss_pkg::TGT_S4); // R15
    end
    else if ((state_ff == ST_RESET) && done)
    begin
      cpu_rst_ff <= 1'b0;
      dev_rst_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake tracking
  // ----------------------------------------------------------------
  // A wake that arrives during entry is held, so the sequence completes
  // cleanly and is then reversed rather than stopped midway.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pend_ff <= 1'b0;
    else if (wake_go)
      pend_ff <= 1'b0;
    else if (hit && ((state_ff == ST_ENTER) || (state_ff == ST_SLEEP)))
      pend_ff <= 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wake_sts_ff <= 1'b0;
    else if (hit && ((state_ff == ST_ENTER) || (state_ff == ST_SLEEP)))
      wake_sts_ff <= 1'b1; // R23
    else if (i_wake_status_clr)
      wake_sts_ff <= 1'b0;
  end

  // The accepted type is kept across the sleep for boot code to inspect.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      type_ff <= '0;
    else if (go)
      type_ff <= i_sleep_type_field; // R21
  end

  assign o_processor_clock_stop_request = ctl_ff[sss_pkg::CB_STOP];
  assign o_cpu_clk_halt = ctl_ff[sss_pkg::CB_HALT];
  assign o_mem_self_refresh = ctl_ff[sss_pkg::CB_SREF];
  assign o_sys_clk_standby = ctl_ff[sss_pkg::CB_STBY];
  assign o_cpu_power_off = ctl_ff[sss_pkg::CB_CPUOFF];
  assign o_mem_isolate = ctl_ff[sss_pkg::CB_ISO];
  assign o_sys_power_off = ctl_ff[sss_pkg::CB_SYSOFF];
  assign o_mem_power_off = ctl_ff[sss_pkg::CB_MEMOFF];
  assign o_cpu_reset = cpu_rst_ff;
  assign o_device_reset = dev_rst_ff;
  assign o_wake_status_bit = wake_sts_ff;
  assign o_sleep_type = type_ff;
  assign o_seq_state = state_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_light_stop_only: assert property ( // R1
    (state_ff == ST_SLEEP) && (tgt_ff == sss_pkg::TGT_S1L) |-> ctl_ff == 8'h01)
    else $error("Light S1 sleep must hold only the clock-stop request.");
  a_light_clocks_run: assert property ( // R2
    (tgt_ff == sss_pkg::TGT_S1L) && (state_ff != ST_WORK) |-> !o_sys_clk_standby && !o_cpu_clk_halt)
    else $error("Light S1 stopped a clock.");
  a_light_wake_release: assert property ( // R3
    (state_ff == ST_SLEEP) && (tgt_ff == sss_pkg::TGT_S1L) && pend_ff |=> !o_processor_clock_stop_request)
    else $error("Clock-stop request held after wake in light S1.");
  a_deep_halt_order: assert property ( // R4
    $rose(o_cpu_clk_halt) |-> o_processor_clock_stop_request && $past(o_processor_clock_stop_request))
    else $error("Processor clock halted before stop grant.");
  a_deep_sref_order: assert property ( // R5
    $rose(o_mem_self_refresh) && (tgt_ff == sss_pkg::TGT_S1D) |-> o_cpu_clk_halt)
    else $error("Deep S1 self-refresh before clock halt.");
  a_deep_stby_last: assert property ( // R6
    $rose(o_sys_clk_standby) && (tgt_ff == sss_pkg::TGT_S1D) |-> o_mem_self_refresh ##1 (state_ff == ST_ENTER)[*8])
    else $error("Deep S1 standby out of order.");
  a_deep_reverse: assert property ( // R7
    $fell(o_mem_self_refresh) && (tgt_ff == sss_pkg::TGT_S1D) |-> !o_sys_clk_standby && o_cpu_clk_halt)
    else $error("Deep S1 wake not in reverse order.");
  a_s2_keep_power: assert property ( // R10
    (tgt_ff == sss_pkg::TGT_S2) && (state_ff != ST_WORK) |-> !o_sys_power_off && !o_mem_power_off)
    else $error("S2 removed core or memory power.");
  a_s2_cpu_reset: assert property ( // R9
    $fell(o_cpu_power_off) && (tgt_ff == sss_pkg::TGT_S2) |-> o_cpu_reset)
    else $error("Processor powered up from S2 without reset.");
  a_s3_isolate: assert property ( // R12
    $rose(o_sys_power_off) && (tgt_ff == sss_pkg::TGT_S3) |-> o_mem_isolate && o_mem_self_refresh)
    else $error("S3 power removed before isolation.");
  a_s3_rtc_only: assert property ( // R14
    (state_ff == ST_SLEEP) && (tgt_ff == sss_pkg::TGT_S3) |-> o_sys_clk_standby && o_sys_power_off)
    else $error("S3 sleep with clocks or power left on.");
  a_wake_sets_status: assert property ( // R23
    hit && (state_ff == ST_SLEEP) |=> o_wake_status_bit)
    else $error("Wake status not set on wakeup.");
  a_bad_type_ignored: assert property ( // R24
    (state_ff == ST_WORK) && i_ctl_wr && (req_tgt == sss_pkg::TGT_NONE) |=> (state_ff == ST_WORK) && $stable(ctl_ff))
    else $error("Unknown sleep type started a sequence.");

  c_light_s1: cover property ((state_ff == ST_SLEEP) && (tgt_ff == sss_pkg::TGT_S1L));
  c_deep_s1_wake: cover property (wake_go && (tgt_ff == sss_pkg::TGT_S1D));
  c_s3_reset: cover property ((state_ff == ST_RESET) && (tgt_ff == sss_pkg::TGT_S3));
  c_s4_sleep: cover property ((state_ff == ST_SLEEP) && (tgt_ff == sss_pkg::TGT_S4));

endmodule

// ---- dv/sss_platform_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Wake sources standing on the platform side
// ----------------------------------------------------------------
module sss_platform_model #(
  parameter int HOLD = 3
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Reset, active low.
  input wire logic i_fire, // Raise one wake event.
  input wire logic [1:0] i_idx, // Which event to raise.
  output logic [3:0] o_wake_events // Event levels to the sequencer.
);
  logic [3:0] hold_ff;
  logic [1:0] idx_ff;

  // A device raises its wake level only briefly, so the sequencer must catch it.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hold_ff <= 4'h0;
      idx_ff <= 2'h0;
    end
    else if (i_fire)
    begin
      hold_ff <= 4'(HOLD);
      idx_ff <= i_idx;
    end
    else if (hold_ff != 4'h0)
      hold_ff <= hold_ff - 4'h1;
  end

  assign o_wake_events = (hold_ff != 4'h0) ? (4'h1 << idx_ff) : 4'h0;
endmodule

// ---- dv/sleep_state_sequencer_tb.sv ----
`timescale 1ns/10ps
module sleep_state_sequencer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic [2:0] typ = 3'h0;
  logic en = 1'b0;
  logic deep = 1'b0;
  logic [3:0] wen = 4'hf;
  logic clr = 1'b0;
  logic fire = 1'b0;
  logic [1:0] idx = 2'h0;
  logic [3:0] wev;
  logic stop, halt, sref, stby, cpuoff, iso, sysoff, memoff, cpurst, devrst, wsts;
  logic [2:0] stype;
  logic [4:0] st;
  logic [7:0] ov;
  int bad_count = 0;
  int cmp_count = 0;
  // Refused writes: unknown types with enable set, then a valid type with enable clear.
  logic [2:0] steps_bad [5] = '{3'h0, 3'h5, 3'h6, 3'h7, 3'h2};

  always #5 clk = ~clk;
  assign ov = {memoff, sysoff, iso, cpuoff, stby, sref, halt, stop};

  sss_sleep_sequencer sss_sleep_sequencer_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_ctl_wr(wr), .i_sleep_type_field(typ),
    .i_sleep_enable_bit(en), .i_s1_deep_mode(deep), .i_wake_events(wev), .i_wake_enables(wen),
    .i_wake_status_clr(clr), .o_processor_clock_stop_request(stop), .o_cpu_clk_halt(halt),
    .o_mem_self_refresh(sref), .o_sys_clk_standby(stby), .o_cpu_power_off(cpuoff),
    .o_mem_isolate(iso), .o_sys_power_off(sysoff), .o_mem_power_off(memoff), .o_cpu_reset(cpurst),
    .o_device_reset(devrst), .o_wake_status_bit(wsts), .o_sleep_type(stype), .o_seq_state(st)
  );

  sss_platform_model sss_platform_model_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_fire(fire), .i_idx(idx), .o_wake_events(wev)
  );

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  // First n control steps of a sequence, packed as ov is packed.
  function automatic logic [7:0] steps(input logic [2:0] t, input logic d, input int n);
    int s[$];
    logic [7:0] v;
    v = 8'h00;
    if (t == sss_pkg::TYPE_S1_DEF && d)
      s = '{0, 1, 2, 3};
    else if (t == sss_pkg::TYPE_S1_DEF)
      s = '{0};
    else if (t == sss_pkg::TYPE_S2_DEF)
      s = '{3, 2, 4};
    else if (t == sss_pkg::TYPE_S3_DEF)
      s = '{2, 5, 3, 6};
    else
      s = '{3, 6, 7};
    for (int i = 0; i < n && i < s.size(); i++)
      v[s[i]] = 1'b1;
    return v;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Type and enable always travel in one write.
  task automatic ctl_write(input logic [2:0] t, input logic e, input logic d);
    @(negedge clk);
    wr = 1'b1;
    typ = t;
    en = e;
    deep = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic wake(input logic [1:0] i);
    @(negedge clk);
    fire = 1'b1;
    idx = i;
    @(negedge clk);
    fire = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // One full sleep and wake cycle
  // ----------------------------------------------------------------
  // Caches are taken as flushed and context as saved before each request.
  task automatic run(input logic [2:0] t, input logic d, input logic [1:0] i, input logic early);
    int n;
    logic seen_cpu, seen_dev;
    seen_cpu = 1'b0;
    seen_dev = 1'b0;
    // Hibernation is always asked for by the control write, never the firmware command port.
    ctl_write(t, 1'b1, d);
    if (early)
      wake(i);
    n = 0;
    while (st === 5'h02 && n < 200)
    begin
      check(ov, steps(t, d, $countones(ov)));
      @(negedge clk);
      n++;
    end
    check(stype, t);
    check(wsts, early);
    if (n >= 200)
    begin
      bad_count++;
      end_sim();
    end
    check(st, 5'h04);
    check(ov, steps(t, d, 8));
    if (!early)
    begin
      wen = 4'hf ^ (4'h1 << i);
      wake(i);
      repeat (8) @(negedge clk);
      check(st, 5'h04);
      check(wsts, 1'b0);
      // A valid type written while asleep must still be refused.
      ctl_write((t % 3'h4) + 3'h1, 1'b1, d);
      check(st, 5'h04);
      check(stype, t);
      wen = 4'hf;
      wake(i);
    end
    n = 0;
    while (st !== 5'h01 && n < 600)
    begin
      check(ov, steps(t, d, $countones(ov)));
      seen_cpu |= cpurst;
      seen_dev |= devrst;
      @(negedge clk);
      n++;
    end
    if (n >= 600)
    begin
      bad_count++;
      end_sim();
    end
    // Boot code is taken to restore processor, cache and memory setup before the next request.
    check(ov, 8'h00);
    check(seen_cpu, t != sss_pkg::TYPE_S1_DEF);
    check(seen_dev, t == sss_pkg::TYPE_S3_DEF || t == sss_pkg::TYPE_S4_DEF);
    check({cpurst, devrst}, 2'h0);
    check(wsts, 1'b1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    check(wsts, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0] t;
    void'($urandom(32'h1766e9a9));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check(st, 5'h01);
    check(ov, 8'h00);
    // Writes that must leave the system working: no enable, or an unknown type.
    ctl_write(sss_pkg::TYPE_S3_DEF, 1'b0, 1'b0);
    check(st, 5'h01);
    foreach (steps_bad[k])
    begin
      ctl_write(steps_bad[k], 1'(k != 4), 1'b1);
      @(negedge clk);
      check(st, 5'h01);
      check(ov, 8'h00);
    end
    for (int k = 0; k < 14; k++)
    begin
      if (k < 5)
        t = (k == 4) ? 3'h1 : 3'(k + 1);
      else
        t = 3'($urandom_range(4, 1));
      run(t, (k == 4) ? 1'b1 : ((k == 0) ? 1'b0 : 1'($urandom)), 2'($urandom),
          (k == 2 || k == 6) ? 1'b1 : 1'($urandom_range(3) == 0));
    end
    end_sim();
  end

  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule
